// file: design/dfs_pkg.sv
// constants and types of the drive fault supervisor
// Functional notes
// - current above pre-alarm level for pre-alarm delay raises pre-alarm and code
// - phase-loss enable: 0 off, 1 output only, 2 input only, 3 both
// - input phase loss held for programmed delay raises fault, coast stop
// - output current above reference with output check on, after 5 s fault
// - max/min phase ratio above coefficient over 10 s faults; 1.00 disables
// - feedback-loss reaction: none, alarm hold, fault coast, alarm decelerate
// - feedback below threshold continuously for detection time triggers reaction
// - serial reaction: 0 fault coast, 1 alarm run, 2 alarm stop
// - no valid serial frame within timeout declares link failure
// - serial timeout of zero disables the serial check
// - keypad reaction: 0 fault coast, 1 fault run, 2 fault stop
// - no keypad data within keypad timeout declares keypad failure
// - storage error: 0 fault coast, 1 alarm and run
// - overload tens digit 2: current at or above threshold for time raises overload
// - count overcurrent/module faults; above limit refuse resets until power cycle
// - knob start digit select: units, tens, hundreds, thousands
// - pre-alarm threshold is percent of rated current, 20 to 200
package dfs_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_MS = 100;                     // timer resolution 0.1 s
   localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
   localparam int OPL_DELAY_S = 5;                   // fixed output phase delay
   localparam int IMB_DELAY_S = 10;                  // imbalance persistence
   localparam logic [15:0] OPL_TICKS = 16'(OPL_DELAY_S * 1000 / TICK_MS);
   localparam logic [15:0] IMB_TICKS = 16'(IMB_DELAY_S * 1000 / TICK_MS);
   localparam logic [9:0] IMB_OFF = 10'h064;         // coefficient 1.00 in hundredths
   localparam logic [9:0] PRE_MIN = 10'h014;         // 20 percent
   localparam logic [9:0] PRE_MAX = 10'h0C8;         // 200 percent
   localparam logic [3:0] TENS_OVLD = 4'h2;
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] CODE_A09 = 8'hA9;
   localparam logic [7:0] CODE_E09 = 8'hE9;
   localparam logic [7:0] CODE_E12 = 8'hEC;
   localparam logic [7:0] CODE_E13 = 8'hED;
   localparam logic [1:0] RX_NONE = 2'h0, RX_HOLD = 2'h1, RX_COAST = 2'h2, RX_DECEL = 2'h3;
   localparam logic [1:0] LK_COAST = 2'h0, LK_RUN = 2'h1, LK_STOP = 2'h2;
   localparam logic [15:0] RST_LIMIT_DEF = 16'h0005;
   localparam logic [1:0] DIGIT_DEF = 2'h1;
   typedef enum logic [2:0] {
      DFS_IDLE = 3'b001,
      DFS_TRIP = 3'b010,
      DFS_LOCK = 3'b100
   } dfs_state_t;
endpackage

// file: design/dfs_timer.sv
// persistence timer: counts ticks while condition holds, clears when it drops
`timescale 1ns/1ps
`default_nettype none
module dfs_timer #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic cond,
   input wire logic [W-1:0] limit,
   output logic expired
);
   logic [W-1:0] cnt_r;
   // count while the condition stands, restart otherwise
   always_ff @(posedge clk) begin
      if (!rst_n || !cond) begin
         cnt_r <= '0;
      end else if (tick && cnt_r < limit) begin
         cnt_r <= cnt_r + 1'b1;
      end
   end
   assign expired = cond && (cnt_r >= limit);
   timer_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
      !cond |=> cnt_r == '0) else $error("timer not restarted");
endmodule
`default_nettype wire

// file: design/dfs_top.sv
// drive fault supervisor top: thresholds, timers, reactions, reset limiting
`timescale 1ns/1ps
`default_nettype none
module dfs_top import dfs_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [9:0] out_cur_pct,
   input wire logic [9:0] ph_a_cur,
   input wire logic [9:0] ph_b_cur,
   input wire logic [9:0] ph_c_cur,
   input wire logic [9:0] prealarm_pct,
   input wire logic [15:0] prealarm_dly,
   input wire logic [1:0] phase_en,
   input wire logic in_phase_lost,
   input wire logic [15:0] in_phase_dly,
   input wire logic [9:0] opl_ref_pct,
   input wire logic [9:0] imb_coef,
   input wire logic [1:0] fb_mode,
   input wire logic [9:0] fb_val,
   input wire logic [9:0] fb_thresh,
   input wire logic [15:0] fb_dly,
   input wire logic [1:0] ser_mode,
   input wire logic [15:0] ser_tmo,
   input wire logic ser_frame_ok,
   input wire logic [1:0] kp_mode,
   input wire logic [15:0] kp_tmo,
   input wire logic kp_data_ok,
   input wire logic nv_mode,
   input wire logic nv_error,
   input wire logic [3:0] ovl_tens,
   input wire logic [9:0] ovl_pct,
   input wire logic [15:0] ovl_dly,
   input wire logic overcurrent_fault,
   input wire logic module_fault,
   input wire logic [15:0] reset_limit,
   input wire logic fault_reset,
   input wire logic [1:0] knob_digit,
   output logic prealarm,
   output logic [7:0] alarm_code,
   output logic [7:0] fault_code,
   output logic fault,
   output logic alarm,
   output logic coast_stop,
   output logic ramp_stop,
   output logic hold_freq,
   output logic reset_locked,
   output logic [3:0] knob_digit_sel
);
   logic [$clog2(TICK_CYCLES)-1:0] div_r;
   logic tick_r;
   // 0.1 s time base shared by every timer
   always_ff @(posedge clk) begin
      if (!rst_n || div_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      tick_r <= rst_n && div_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);
   end

   // phase-loss enable decode and thresholds
   logic in_en, out_en, pre_c, ipl_c, opl_c, imb_c, fb_c, ovl_c;
   logic [9:0] pre_lvl, ph_max, ph_min;
   assign in_en = phase_en[1];
   assign out_en = phase_en[0];
   assign pre_lvl = (prealarm_pct < PRE_MIN) ? PRE_MIN : (prealarm_pct > PRE_MAX) ? PRE_MAX : prealarm_pct;
   assign pre_c = out_cur_pct > pre_lvl;
   assign ipl_c = in_en && in_phase_lost;
   assign opl_c = out_en && out_cur_pct > opl_ref_pct;
   always_comb begin
      ph_max = ph_a_cur;
      ph_min = ph_a_cur;
      if (ph_b_cur > ph_max) ph_max = ph_b_cur;
      if (ph_c_cur > ph_max) ph_max = ph_c_cur;
      if (ph_b_cur < ph_min) ph_min = ph_b_cur;
      if (ph_c_cur < ph_min) ph_min = ph_c_cur;
   end
   // ratio max/min > coef/100 checked as max*100 > coef*min
   assign imb_c = imb_coef > IMB_OFF && (20'(ph_max) * 20'(IMB_OFF)) > (20'(imb_coef) * 20'(ph_min));
   assign fb_c = fb_mode != RX_NONE && fb_val < fb_thresh;
   assign ovl_c = ovl_tens == TENS_OVLD && out_cur_pct >= ovl_pct;

   // link watchdogs: condition is absence of valid traffic
   logic ser_c, kp_c;
   assign ser_c = ser_tmo != 16'h0000 && !ser_frame_ok;
   assign kp_c = !kp_data_ok;

   // timer slots, one persistence timer for each supervised condition except the storage error
   localparam int TMR_N = 8;
   localparam int T_PRE = 0;
   localparam int T_IPL = 1;
   localparam int T_OPL = 2;
   localparam int T_IMB = 3;
   localparam int T_FB = 4;
   localparam int T_OVL = 5;
   localparam int T_SER = 6;
   localparam int T_KP = 7;
   logic [TMR_N-1:0] tmr_cond, tmr_exp;
   logic [15:0] tmr_limit [TMR_N];
   logic pre_x, ipl_x, opl_x, imb_x, fb_x, ovl_x, ser_x, kp_x;
   // gather conditions into their slots
   assign tmr_cond[T_PRE] = pre_c;
   assign tmr_cond[T_IPL] = ipl_c;
   assign tmr_cond[T_OPL] = opl_c;
   assign tmr_cond[T_IMB] = imb_c;
   assign tmr_cond[T_FB] = fb_c;
   assign tmr_cond[T_OVL] = ovl_c;
   assign tmr_cond[T_SER] = ser_c;
   assign tmr_cond[T_KP] = kp_c;
   // limits in ticks; output phase and imbalance delays are fixed
   assign tmr_limit[T_PRE] = prealarm_dly;
   assign tmr_limit[T_IPL] = in_phase_dly;
   assign tmr_limit[T_OPL] = OPL_TICKS;
   assign tmr_limit[T_IMB] = IMB_TICKS;
   assign tmr_limit[T_FB] = fb_dly;
   assign tmr_limit[T_OVL] = ovl_dly;
   assign tmr_limit[T_SER] = ser_tmo;
   assign tmr_limit[T_KP] = kp_tmo;
   // one timer per slot, all on the shared tick
   for (genvar gi = 0; gi < TMR_N; gi++) begin : g_tmr
      dfs_timer u_tmr (
         .clk(clk),
         .rst_n(rst_n),
         .tick(tick_r),
         .cond(tmr_cond[gi]),
         .limit(tmr_limit[gi]),
         .expired(tmr_exp[gi])
      );
   end
   // expiry flags by name for the reaction decode
   assign pre_x = tmr_exp[T_PRE];
   assign ipl_x = tmr_exp[T_IPL];
   assign opl_x = tmr_exp[T_OPL];
   assign imb_x = tmr_exp[T_IMB];
   assign fb_x = tmr_exp[T_FB];
   assign ovl_x = tmr_exp[T_OVL];
   assign ser_x = tmr_exp[T_SER];
   assign kp_x = tmr_exp[T_KP];

   // reaction decode for this cycle
   logic f_now, a_now, c_now, r_now, h_now;
   logic [7:0] fcode_now;
   always_comb begin
      f_now = 1'b0;
      a_now = 1'b0;
      c_now = 1'b0;
      r_now = 1'b0;
      h_now = 1'b0;
      fcode_now = CODE_NONE;
      if (ipl_x) begin
         f_now = 1'b1;
         c_now = 1'b1;
         fcode_now = CODE_E12;
      end else if (opl_x || imb_x) begin
         f_now = 1'b1;
         c_now = opl_x;
         fcode_now = CODE_E13;
      end else if (ovl_x) begin
         f_now = 1'b1;
         c_now = 1'b1;
         fcode_now = CODE_E09;
      end
      if (fb_x) begin
         case (fb_mode)
            RX_HOLD: begin
               a_now = 1'b1;
               h_now = 1'b1;
            end
            RX_COAST: begin
               f_now = 1'b1;
               c_now = 1'b1;
            end
            RX_DECEL: begin
               a_now = 1'b1;
               r_now = 1'b1;
            end
            default: ;
         endcase
      end
      if (ser_x) begin
         case (ser_mode)
            LK_COAST: begin
               f_now = 1'b1;
               c_now = 1'b1;
            end
            LK_RUN: a_now = 1'b1;
            LK_STOP: begin
               a_now = 1'b1;
               r_now = 1'b1;
            end
            default: a_now = 1'b1;
         endcase
      end
      if (kp_x) begin
         case (kp_mode)
            LK_COAST: begin
               f_now = 1'b1;
               c_now = 1'b1;
            end
            LK_RUN: f_now = 1'b1;
            LK_STOP: begin
               f_now = 1'b1;
               r_now = 1'b1;
            end
            default: f_now = 1'b1;
         endcase
      end
      if (nv_error) begin
         if (nv_mode) begin
            a_now = 1'b1;
         end else begin
            f_now = 1'b1;
            c_now = 1'b1;
         end
      end
   end

   // fault latch state machine: trips hold until an accepted reset
   dfs_state_t st_r, st_nxt;
   logic [15:0] oc_cnt_r;
   logic oc_prev_r, mod_prev_r, lock_now;
   assign lock_now = oc_cnt_r > reset_limit;
   always_comb begin
      case (st_r)
         DFS_IDLE: st_nxt = f_now ? DFS_TRIP : DFS_IDLE;
         DFS_TRIP: st_nxt = lock_now ? DFS_LOCK : (fault_reset && !f_now) ? DFS_IDLE : DFS_TRIP;
         DFS_LOCK: st_nxt = DFS_LOCK; // only a power cycle leaves
         default: st_nxt = DFS_IDLE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (!rst_n) st_r <= DFS_IDLE;
      else st_r <= st_nxt;
   end

   // count rising overcurrent and module faults, saturating
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         oc_cnt_r <= 16'h0000;
         oc_prev_r <= 1'b0;
         mod_prev_r <= 1'b0;
      end else begin
         oc_prev_r <= overcurrent_fault;
         mod_prev_r <= module_fault;
         if (((overcurrent_fault && !oc_prev_r) || (module_fault && !mod_prev_r)) && oc_cnt_r != 16'hFFFF)
            oc_cnt_r <= oc_cnt_r + 16'h0001;
      end
   end

   // registered outputs
   logic [7:0] fcode_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prealarm <= 1'b0;
         alarm_code <= CODE_NONE;
         fault_code <= CODE_NONE;
         fcode_r <= CODE_NONE;
         fault <= 1'b0;
         alarm <= 1'b0;
         coast_stop <= 1'b0;
         ramp_stop <= 1'b0;
         hold_freq <= 1'b0;
         reset_locked <= 1'b0;
      end else begin
         prealarm <= pre_x;
         alarm_code <= pre_x ? CODE_A09 : CODE_NONE;
         if (st_r == DFS_IDLE && f_now) fcode_r <= fcode_now;
         else if (st_nxt == DFS_IDLE) fcode_r <= CODE_NONE;
         fault_code <= (st_r == DFS_IDLE && f_now) ? fcode_now : (st_nxt == DFS_IDLE ? CODE_NONE : fcode_r);
         fault <= st_nxt != DFS_IDLE;
         alarm <= a_now || pre_x;
         coast_stop <= c_now || (st_nxt != DFS_IDLE && coast_stop);
         ramp_stop <= r_now;
         hold_freq <= h_now;
         reset_locked <= st_nxt == DFS_LOCK;
      end
   end

   // knob start digit one-hot select
   always_ff @(posedge clk) begin
      if (!rst_n) knob_digit_sel <= 4'h1 << DIGIT_DEF;
      else knob_digit_sel <= 4'h1 << knob_digit;
   end

   pre_out_a: assert property (@(posedge clk) disable iff (!rst_n)
      pre_x |=> prealarm && alarm_code == CODE_A09) else $error("pre-alarm missing");
   phase_dec_a: assert property (@(posedge clk) disable iff (!rst_n)
      phase_en == 2'h1 |-> !in_en && out_en) else $error("phase decode");
   in_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
      ipl_x |=> fault && coast_stop) else $error("input phase fault");
   out_phase_a: assert property (@(posedge clk) disable iff (!rst_n)
      !out_en |-> !opl_c) else $error("output phase gate");
   imb_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      imb_coef == IMB_OFF |-> !imb_c) else $error("imbalance not disabled");
   fb_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      fb_x && fb_mode == RX_HOLD |=> alarm && hold_freq) else $error("feedback hold");
   ser_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      ser_tmo == 16'h0000 |-> !ser_x) else $error("serial check not off");
   lock_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_r == DFS_LOCK |=> st_r == DFS_LOCK ##1 reset_locked) else $error("lock released");
   lock_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
      st_r == DFS_LOCK && fault_reset |=> fault && reset_locked) else $error("reset accepted while locked");
   nv_alarm_a: assert property (@(posedge clk) disable iff (!rst_n)
      nv_error && nv_mode && !ipl_x && !opl_x && !imb_x && !ovl_x && !fb_x && !ser_x && !kp_x && st_r == DFS_IDLE
      |=> !fault && alarm) else $error("storage alarm");
endmodule
`default_nettype wire

// file: sim/test_dfs_top.sv
// self-checking testbench of the drive fault supervisor top
`timescale 1ns/1ps
`default_nettype none
module test_dfs_top;
   import dfs_pkg::*;
   localparam int TC = 4;
   logic clk = 0, rst_n = 0, in_phase_lost = 0, ser_frame_ok = 1, kp_data_ok = 1, nv_mode = 0, nv_error = 0;
   logic overcurrent_fault = 0, module_fault = 0, fault_reset = 0;
   logic [9:0] out_cur_pct = 0, ph_a_cur = 10'h064, ph_b_cur = 10'h064, ph_c_cur = 10'h064;
   logic [9:0] prealarm_pct = 10'h0C8, opl_ref_pct = 10'h032, imb_coef = 10'h064, fb_val = 10'h3FF;
   logic [9:0] fb_thresh = 10'h032, ovl_pct = 10'h096;
   logic [15:0] prealarm_dly = 5, in_phase_dly = 2, fb_dly = 3, ser_tmo = 0, kp_tmo = 3, ovl_dly = 2;
   logic [15:0] reset_limit = 2;
   logic [1:0] phase_en = 0, fb_mode = 0, ser_mode = 1, kp_mode = 1, knob_digit = 1;
   logic [3:0] ovl_tens = 0, knob_digit_sel;
   logic prealarm, fault, alarm, coast_stop, ramp_stop, hold_freq, reset_locked;
   logic [7:0] alarm_code, fault_code;
   int failures = 0, cmp_count = 0, cyc = 0;
   dfs_top #(.TICK_CYCLES(TC)) dut (.clk(clk), .rst_n(rst_n), .out_cur_pct(out_cur_pct), .ph_a_cur(ph_a_cur),
      .ph_b_cur(ph_b_cur), .ph_c_cur(ph_c_cur), .prealarm_pct(prealarm_pct), .prealarm_dly(prealarm_dly),
      .phase_en(phase_en), .in_phase_lost(in_phase_lost), .in_phase_dly(in_phase_dly), .opl_ref_pct(opl_ref_pct),
      .imb_coef(imb_coef), .fb_mode(fb_mode), .fb_val(fb_val), .fb_thresh(fb_thresh), .fb_dly(fb_dly),
      .ser_mode(ser_mode), .ser_tmo(ser_tmo), .ser_frame_ok(ser_frame_ok), .kp_mode(kp_mode), .kp_tmo(kp_tmo),
      .kp_data_ok(kp_data_ok), .nv_mode(nv_mode), .nv_error(nv_error), .ovl_tens(ovl_tens), .ovl_pct(ovl_pct),
      .ovl_dly(ovl_dly), .overcurrent_fault(overcurrent_fault), .module_fault(module_fault),
      .reset_limit(reset_limit), .fault_reset(fault_reset), .knob_digit(knob_digit), .prealarm(prealarm),
      .alarm_code(alarm_code), .fault_code(fault_code), .fault(fault), .alarm(alarm), .coast_stop(coast_stop),
      .ramp_stop(ramp_stop), .hold_freq(hold_freq), .reset_locked(reset_locked), .knob_digit_sel(knob_digit_sel));
   // clock of 25 ns period
   initial begin
      forever #12.5 clk = ~clk;
   end
   // hang guard well above the expected run length
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         results();
      end
   end
   task automatic check(logic [15:0] seen, logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // reaction outputs packed as fault, alarm, coast, ramp, hold
   function automatic logic [15:0] rx();
      return {11'h000, fault, alarm, coast_stop, ramp_stop, hold_freq};
   endfunction
   task automatic do_reset();
      rst_n = 0;
      wait_cyc(5);
      rst_n = 1;
   endtask
   task automatic t_reset_knob();
      check({2'h0, reset_locked, knob_digit_sel, fault_code, prealarm}, 16'h0400);
      for (int d = 0; d < 4; d++) begin
         knob_digit = d[1:0];
         wait_cyc(2);
         check({12'h000, knob_digit_sel}, 16'h0001 << d);
      end
      $display("test knob done");
   endtask
   task automatic t_prealarm();
      prealarm_pct = 10'h064;
      out_cur_pct = 10'h096;
      wait_cyc(3 * TC);
      out_cur_pct = 10'h050;
      wait_cyc(1);
      out_cur_pct = 10'h096;
      wait_cyc(3 * TC);
      check({15'h0, prealarm}, 16'h0000);
      wait_cyc(4 * TC);
      check({7'h0, prealarm, alarm_code}, 16'h01A9);
      prealarm_pct = 10'h005;
      out_cur_pct = 10'h010;
      wait_cyc(8 * TC);
      check({15'h0, prealarm}, 16'h0000);
      out_cur_pct = 10'h000;
      $display("test prealarm done");
   endtask
   task automatic t_in_phase();
      in_phase_lost = 1;
      wait_cyc(5 * TC);
      check(rx(), 16'h0000);
      phase_en = 2'h1;
      wait_cyc(5 * TC);
      check(rx(), 16'h0000);
      phase_en = 2'h2;
      wait_cyc(5 * TC);
      check({fault_code, 3'h0, fault, alarm, coast_stop, ramp_stop, hold_freq}, 16'hEC14);
      in_phase_lost = 0;
      phase_en = 2'h0;
      fault_reset = 1;
      wait_cyc(3);
      fault_reset = 0;
      wait_cyc(2);
      check(rx(), 16'h0000);
      $display("test input phase done");
   endtask
   task automatic t_serial();
      logic [4:0] exp [3] = '{5'h14, 5'h08, 5'h0A};
      ser_frame_ok = 0;
      wait_cyc(10 * TC);
      check(rx(), 16'h0000);
      for (int m = 0; m < 3; m++) begin
         do_reset();
         ser_mode = m[1:0];
         ser_tmo = 3;
         wait_cyc(6 * TC);
         check(rx(), {11'h0, exp[m]});
      end
      ser_frame_ok = 1;
      ser_tmo = 0;
      do_reset();
      $display("test serial done");
   endtask
   task automatic t_feedback_keypad();
      logic [4:0] fexp [4] = '{5'h00, 5'h09, 5'h14, 5'h0A};
      logic [4:0] kexp [3] = '{5'h14, 5'h10, 5'h12};
      for (int m = 0; m < 4; m++) begin
         fb_mode = m[1:0];
         fb_val = 10'h000;
         wait_cyc(6 * TC);
         check(rx(), {11'h0, fexp[m]});
         fb_val = 10'h3FF;
         do_reset();
      end
      fb_mode = 0;
      for (int m = 0; m < 3; m++) begin
         kp_mode = m[1:0];
         kp_data_ok = 0;
         wait_cyc(6 * TC);
         check(rx(), {11'h0, kexp[m]});
         kp_data_ok = 1;
         do_reset();
      end
      for (int m = 0; m < 2; m++) begin
         nv_mode = m[0];
         nv_error = 1;
         wait_cyc(4);
         check(rx(), m ? 16'h0008 : 16'h0014);
         nv_error = 0;
         do_reset();
      end
      $display("test feedback keypad storage done");
   endtask
   task automatic t_overload_lock();
      out_cur_pct = 10'h096;
      ovl_tens = 4'h1;
      wait_cyc(5 * TC);
      check({8'h0, fault_code}, 16'h0000);
      ovl_tens = TENS_OVLD;
      wait_cyc(5 * TC);
      check({8'h0, fault_code}, 16'h00E9);
      out_cur_pct = 10'h000;
      ovl_tens = 0;
      for (int i = 1; i <= 3; i++) begin
         overcurrent_fault = i != 2;
         module_fault = i == 2;
         wait_cyc(2);
         overcurrent_fault = 0;
         module_fault = 0;
         wait_cyc(3);
         check({15'h0, reset_locked}, {15'h0, i > 2});
      end
      fault_reset = 1;
      wait_cyc(3);
      fault_reset = 0;
      check({14'h0, fault, reset_locked}, 16'h0003);
      do_reset();
      check({14'h0, fault, reset_locked}, 16'h0000);
      $display("test overload lock done");
   endtask
   task automatic t_imbalance();
      ph_a_cur = 10'h12C;
      wait_cyc((32'(IMB_TICKS) + 4) * TC);
      check({8'h0, fault_code}, 16'h0000);
      imb_coef = 10'h0C8;
      wait_cyc((32'(IMB_TICKS) - 2) * TC);
      check({8'h0, fault_code}, 16'h0000);
      wait_cyc(6 * TC);
      check({8'h0, fault_code}, 16'h00ED);
      ph_a_cur = 10'h064;
      do_reset();
      phase_en = 2'h3;
      out_cur_pct = 10'h03C;
      wait_cyc((32'(OPL_TICKS) - 2) * TC);
      check({8'h0, fault_code}, 16'h0000);
      wait_cyc(5 * TC);
      check({fault_code, 3'h0, fault, 1'b0, coast_stop, 2'h0}, 16'hED14);
      $display("test imbalance phase done");
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      do_reset();
      t_reset_knob();
      t_prealarm();
      t_in_phase();
      t_serial();
      t_feedback_keypad();
      t_overload_lock();
      t_imbalance();
      results();
   end
endmodule
`default_nettype wire
